/* shared/wake_source_params.svh */
`ifndef WAKE_SOURCE_PARAMS_SVH
`define WAKE_SOURCE_PARAMS_SVH

// ****************************************************************
// register addresses on the decoded access port
// ****************************************************************
`define BUS_CTRL_ADDR        7'h04
`define WAKE_CTRL_ADDR       7'h05

// ****************************************************************
// transceiver mode field values
// ****************************************************************
`define CAN_POR_RESET        3'h0
`define CAN_DEV_RESET        3'h1
`define CAN_FAILSAFE         3'h1
`define CAN_LOW_WAKE         2'h1
`define CAN_LOW_RECEIVE      2'h2
`define CAN_LOW_NORMAL       2'h3

// ****************************************************************
// wake control field positions
// ****************************************************************
`define WK_ROLE_BIT          15
`define WAKE_FILTER_SELECT_MSB          13
`define WAKE_FILTER_SELECT_LSB          11
`define WK_PULL_MSB          10
`define WK_PULL_LSB          9
`define INPUT_ENABLE_SELECT_MSB            6
`define INPUT_ENABLE_SELECT_LSB            5
`define WK_BANK_MSB          2
`define WK_BANK_LSB          0

// ****************************************************************
// wake control codes and reset values
// ****************************************************************
`define BANK_SHARED          3'h1
`define BANK_STROBE          3'h3
`define BANK_FIXED_PULL      3'h4
`define BANK_LAST            3'h4
`define FILT_STATIC_16       3'h0
`define FILT_STROBE          3'h4
`define FILT_LAST            3'h4
`define PULL_NONE            2'h0
`define PULL_UP              2'h2
`define EN_OFF               2'h0
`define EN_ON                2'h1
`define EN_STROBE            2'h2
`define WAKE_CTRL_RESET      16'h0020

`endif

/* shared/wake_pkg.sv */
package wake_pkg;

  // ****************************************************************
  // per-input configuration carrier
  // ****************************************************************
  typedef struct packed
  {
    logic [2:0] filter;   // filter time select
    logic [1:0] pull;     // pull resistor select
    logic [1:0] enable;   // input enable select
  } wake_cfg_s;

  // transceiver mode field
  typedef logic [2:0] can_mode_t;

endpackage

/* verilog/wake_source_control.sv */
// Operation
// RULE1: mode field: low bits mode, top bit selective
// RULE2: hardware never changes selective wake bit; code clears it on restart and fail-safe entry
// RULE3: sleep without error turns normal into wake
// RULE4: receive only becomes wake on sleep, kept stop
// RULE5: wake or off unchanged on low power
// RULE6: host selects receive only before stop
// RULE7: fail-safe entry forces transceiver to wake
// RULE8: development mode resets transceiver to wake
// RULE9: restart loads cause-dependent low mode bits
// RULE10: bit fifteen picks fail output or wake
// RULE11: shared pin bit reachable only in bank two
// RULE12: filter codes select static, timer, strobe filtering
// RULE13: pull codes none, down, up, automatic
// RULE14: fifth input pull field reserved, fixed up
// RULE15: enable codes off, on, fourth strobe
// RULE16: strobe only in bank four, enabled fourth
// RULE17: bank codes zero to four pick inputs
// RULE18: host uses on-time at least 100 us
// RULE19: host assigns timer or strobe to switch
// RULE20: fail-safe entry enables inputs, two exceptions
// RULE21: fail-safe uses static sixteen microsecond filter
// RULE22: per-input fields stored separately for each bank
`timescale 1ns/10ps
`default_nettype none
`include "wake_source_params.svh"

module wake_source_control (
  input  wire logic                      mclk,              // device clock, 200 MHz
  input  wire logic                      rst,               // power-on or soft reset
  input  wire logic                      restart_rst,       // restart reset pulse
  input  wire logic                      dev_mode,          // development operating mode
  input  wire logic                      system_error_flag, // system error flag
  input  wire logic                      sleep_entry,       // sleep mode entry pulse
  input  wire logic                      stop_entry,        // stop mode entry pulse
  input  wire logic                      failsafe_entry,    // fail-safe entry pulse
  input  wire logic                      failsafe_active,   // fail-safe mode level
  input  wire logic [1:0]                restart_can_low,   // cause-dependent restart mode
  input  wire logic                      reg_wr,            // register write strobe
  input  wire logic                      reg_rd,            // register read strobe
  input  wire logic [6:0]                reg_addr,          // register address
  input  wire logic [15:0]               reg_wdata,         // register write data
  output logic      [15:0]               reg_rdata,         // register read data
  output wake_pkg::can_mode_t            transceiver_mode,  // transceiver mode field
  output logic                           shared_pin_role_select, // 1 wake input, 0 fail output
  output logic                           strobe_input_active,    // fourth input is strobe
  output wake_pkg::wake_cfg_s [4:0]      input_config       // effective per-input setup
);

  // ****************************************************************
  // storage and decode
  // ****************************************************************
  wake_pkg::wake_cfg_s [4:0] cfg;         // stored per-input settings
  logic [2:0]                bank;        // selected input bank
  logic                      wr_bus;      // write to transceiver register
  logic                      wr_wake;     // write to wake control register
  logic [2:0]                wbank;       // bank carried by the write
  logic                      wbank_ok;    // written bank is a real input
  logic [15:0]               rd_word;     // read mux result
  wake_pkg::wake_cfg_s       sel;         // settings of the selected bank
  // power-on image of the wake control register, split into fields below
  localparam logic [15:0]    WAKE_RESET_IMG = `WAKE_CTRL_RESET;

  // address decode of the access port
  assign wr_bus   = reg_wr && (reg_addr == `BUS_CTRL_ADDR);
  assign wr_wake  = reg_wr && (reg_addr == `WAKE_CTRL_ADDR);
  assign wbank    = reg_wdata[`WK_BANK_MSB:`WK_BANK_LSB];
  // RULE17: reserved bank codes
  assign wbank_ok = (wbank <= `BANK_LAST);
  assign sel      = cfg[bank];

  // ****************************************************************
  // transceiver mode field
  // ****************************************************************
  // hardware events take priority over a host write in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      // RULE8: development reset value
      transceiver_mode <= dev_mode ? `CAN_DEV_RESET : `CAN_POR_RESET;
    end
    else if (restart_rst)
    begin
      // RULE9: cause-dependent restart value
      transceiver_mode <= {1'b0, restart_can_low};
    end
    else if (failsafe_entry)
    begin
      // RULE7: wake capable on fail-safe
      transceiver_mode <= `CAN_FAILSAFE;
    end
    else if (sleep_entry)
    begin
      // RULE3: normal to wake on sleep
      if ((transceiver_mode[1:0] == `CAN_LOW_NORMAL) && !system_error_flag)
      begin
        // RULE2: only the low bits move
        transceiver_mode[1:0] <= `CAN_LOW_WAKE;
      end
      // RULE4: receive only to wake on sleep
      else if (transceiver_mode[1:0] == `CAN_LOW_RECEIVE)
      begin
        transceiver_mode[1:0] <= `CAN_LOW_WAKE;
      end
      // RULE5: wake and off stay as they are
    end
    else if (stop_entry)
    begin
      // RULE4: stop keeps receive only and every other setting
      transceiver_mode <= transceiver_mode;
    end
    else if (wr_bus)
    begin
      // RULE1: host writes the full field
      transceiver_mode <= reg_wdata[2:0];
    end
  end

  // ****************************************************************
  // bank select and shared pin role
  // ****************************************************************
  // bank is cleared on restart, shared pin role survives it
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bank <= 3'h0;
    end
    else if (restart_rst)
    begin
      bank <= 3'h0;
    end
    // RULE17: reserved bank codes are not stored
    else if (wr_wake && wbank_ok)
    begin
      bank <= wbank;
    end
  end

  // shared pin role write, only with bank two in the same write
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shared_pin_role_select <= 1'b0;
    end
    // RULE11: write gated by bank two
    else if (wr_wake && (wbank == `BANK_SHARED))
    begin
      // RULE10: 0 fail output, 1 wake input
      shared_pin_role_select <= reg_wdata[`WK_ROLE_BIT];
    end
  end

  // ****************************************************************
  // per-input settings and effective outputs
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_input
      localparam logic [2:0] IDX = 3'(gi);   // bank code of this input
      logic hit;                             // this input addressed by the write
      logic keep_en;                         // excepted from fail-safe enable

      assign hit = wr_wake && wbank_ok && (wbank == IDX);
      // RULE20: shared pin as fail output, fourth input as strobe
      assign keep_en = ((IDX == `BANK_SHARED) && !shared_pin_role_select) ||
                       ((IDX == `BANK_STROBE) && (cfg[gi].enable == `EN_STROBE));

      // stored settings of this input
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          // field-wise, so the enable bit of the image lands in the enable field
          cfg[gi] <= {WAKE_RESET_IMG[`WAKE_FILTER_SELECT_MSB:`WAKE_FILTER_SELECT_LSB], WAKE_RESET_IMG[`WK_PULL_MSB:`WK_PULL_LSB],
                      WAKE_RESET_IMG[`INPUT_ENABLE_SELECT_MSB:`INPUT_ENABLE_SELECT_LSB]};
        end
        else if (failsafe_entry)
        begin
          // RULE20: force enable on
          if (!keep_en)
          begin
            cfg[gi].enable <= `EN_ON;
          end
        end
        // RULE22: write lands in the addressed input only
        else if (hit)
        begin
          // RULE12: reserved filter codes ignored
          if (reg_wdata[`WAKE_FILTER_SELECT_MSB:`WAKE_FILTER_SELECT_LSB] <= `FILT_LAST)
          begin
            cfg[gi].filter <= reg_wdata[`WAKE_FILTER_SELECT_MSB:`WAKE_FILTER_SELECT_LSB];
          end
          // RULE14: pull field reserved in bank five
          if (IDX != `BANK_FIXED_PULL)
          begin
            // RULE13: pull code stored
            cfg[gi].pull <= reg_wdata[`WK_PULL_MSB:`WK_PULL_LSB];
          end
          // RULE15: enable code stored
          cfg[gi].enable <= reg_wdata[`INPUT_ENABLE_SELECT_MSB:`INPUT_ENABLE_SELECT_LSB];
        end
      end

      // effective configuration seen by the wake front end
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          input_config[gi] <= '0;
        end
        else
        begin
          // RULE21: fail-safe uses static 16 us filter
          if (failsafe_active)
          begin
            input_config[gi].filter <= `FILT_STATIC_16;
          end
          // RULE16: strobe filter needs strobe input
          else if ((cfg[gi].filter == `FILT_STROBE) && (cfg[3].enable != `EN_STROBE))
          begin
            input_config[gi].filter <= `FILT_STATIC_16;
          end
          else
          begin
            input_config[gi].filter <= cfg[gi].filter;
          end
          // RULE14: fixed pull-up on fifth input
          input_config[gi].pull <= (IDX == `BANK_FIXED_PULL) ? `PULL_UP : cfg[gi].pull;
          // RULE15: only code 01 turns the input on
          if ((cfg[gi].enable == `EN_ON) && !((IDX == `BANK_SHARED) && !shared_pin_role_select))
          begin
            input_config[gi].enable <= `EN_ON;
          end
          else
          begin
            input_config[gi].enable <= `EN_OFF;
          end
        end
      end
    end
  endgenerate

  // strobe input role of the fourth input
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      strobe_input_active <= 1'b0;
    end
    else
    begin
      // RULE16: strobe only on fourth input
      strobe_input_active <= (cfg[3].enable == `EN_STROBE);
    end
  end

  // ****************************************************************
  // register read path
  // ****************************************************************
  // read mux, reserved bits and unmapped addresses read zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (reg_addr == `BUS_CTRL_ADDR)
    begin
      rd_word[2:0] = transceiver_mode;
    end
    else if (reg_addr == `WAKE_CTRL_ADDR)
    begin
      // RULE11: shared pin bit visible in bank two
      rd_word[`WK_ROLE_BIT] = (bank == `BANK_SHARED) ? shared_pin_role_select : 1'b0;
      rd_word[`WAKE_FILTER_SELECT_MSB:`WAKE_FILTER_SELECT_LSB] = sel.filter;
      // RULE14: reserved pull field reads zero
      rd_word[`WK_PULL_MSB:`WK_PULL_LSB] = (bank == `BANK_FIXED_PULL) ? `PULL_NONE : sel.pull;
      rd_word[`INPUT_ENABLE_SELECT_MSB:`INPUT_ENABLE_SELECT_LSB] = sel.enable;
      rd_word[`WK_BANK_MSB:`WK_BANK_LSB] = bank;
    end
  end

  // read data register, holds until the next read
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rd_word;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  swk_bit_hold_a : assert property (@(posedge mclk) disable iff (rst) // RULE2
    $changed(transceiver_mode[2]) |->
      ($past(wr_bus) || $past(restart_rst) || $past(failsafe_entry) || $past(rst)))
    else $error("selective wake bit changed without host write");

  sleep_normal_a : assert property (@(posedge mclk) disable iff (rst) // RULE3
    (sleep_entry && !restart_rst && !failsafe_entry && !system_error_flag &&
     (transceiver_mode[1:0] == 2'h3)) |=>
      ((transceiver_mode[1:0] == 2'h1) && (transceiver_mode[2] == $past(transceiver_mode[2]))))
    else $error("normal mode not turned to wake on sleep");

  sleep_receive_a : assert property (@(posedge mclk) disable iff (rst) // RULE4
    (sleep_entry && !restart_rst && !failsafe_entry && (transceiver_mode[1:0] == 2'h2)) |=>
      (transceiver_mode[1:0] == 2'h1))
    else $error("receive only not turned to wake on sleep");

  stop_keep_a : assert property (@(posedge mclk) disable iff (rst) // RULE5
    (stop_entry && !sleep_entry && !restart_rst && !failsafe_entry) |=> $stable(transceiver_mode))
    else $error("mode changed on stop entry");

  failsafe_mode_a : assert property (@(posedge mclk) disable iff (rst) // RULE7
    (failsafe_entry && !restart_rst) |=> (transceiver_mode == 3'h1) [*1] ##0 (reg_rdata == $past(reg_rdata) || $past(reg_rd)))
    else $error("fail-safe did not force wake capable");

  dev_reset_a : assert property (@(posedge mclk) // RULE8
    (rst && dev_mode) |=> (transceiver_mode == 3'h1))
    else $error("development reset value wrong");

  restart_low_a : assert property (@(posedge mclk) disable iff (rst) // RULE9
    restart_rst |=> ((transceiver_mode == {1'b0, $past(restart_can_low)}) && (bank == 3'h0)))
    else $error("restart mode bits wrong");

  role_guard_a : assert property (@(posedge mclk) disable iff (rst) // RULE11
    (!wr_wake || (reg_wdata[2:0] != 3'h1)) |=> $stable(shared_pin_role_select))
    else $error("shared pin role changed outside bank two");

  fixed_pull_a : assert property (@(posedge mclk) disable iff (rst) // RULE14
    1'b1 |=> ((input_config[4].pull == 2'h2) &&
              (!$past(reg_rd && (reg_addr == 7'h05) && (bank == 3'h4)) || (reg_rdata[10:9] == 2'h0))))
    else $error("fifth input pull not fixed or readable");

  failsafe_enable_a : assert property (@(posedge mclk) disable iff (rst) // RULE20
    (failsafe_entry && !restart_rst) |=> (cfg[0].enable == 2'h1) ##1 (input_config[0].enable == 2'h1))
    else $error("fail-safe did not enable first input");

  failsafe_filter_a : assert property (@(posedge mclk) disable iff (rst) // RULE21
    failsafe_active |=> (input_config[2].filter == 3'h0))
    else $error("filter not static during fail-safe");

  sleep_cover_c : cover property (@(posedge mclk) disable iff (rst)
    sleep_entry && (transceiver_mode[1:0] == 2'h3) ##1 (transceiver_mode[1:0] == 2'h1));

  failsafe_cover_c : cover property (@(posedge mclk) disable iff (rst)
    failsafe_entry && (cfg[3].enable == 2'h2) ##1 strobe_input_active);

  bank_cover_c : cover property (@(posedge mclk) disable iff (rst)
    wr_wake && (reg_wdata[2:0] == 3'h1) ##2 reg_rd && (reg_addr == 7'h05));

endmodule // wake_source_control

`default_nettype wire

/* verification/wake_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// host side of the decoded register port
// ****************************************************************
module wake_host_model (
  input  wire logic        mclk,       // device clock
  output logic             reg_wr,     // write strobe
  output logic             reg_rd,     // read strobe
  output logic [6:0]       reg_addr,   // register address
  output logic [15:0]      reg_wdata,  // write data
  input  wire logic [15:0] reg_rdata   // registered read data
);
  // idle bus, address parked on an unmapped value
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h7f;
    reg_wdata = 16'h0000;
  end

  // one write cycle; released lines show the inverse so stale values never match
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // one read cycle; data taken a full cycle after the strobe edge
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule // wake_host_model

`default_nettype wire

/* verification/test_wake_source_control.sv */
`timescale 1ns/10ps
`default_nettype none

module test_wake_source_control;
  logic                          mclk, rst, restart_rst, dev_mode, system_error_flag;
  logic                          sleep_entry, stop_entry, failsafe_entry, failsafe_active;
  logic [1:0]                    restart_can_low;   // restart mode bits
  logic                          reg_wr, reg_rd;    // host strobes
  logic [6:0]                    reg_addr;          // host address
  logic [15:0]                   reg_wdata, reg_rdata, rd_val;
  wake_pkg::can_mode_t           transceiver_mode;  // mode field seen
  logic                          shared_pin_role_select, strobe_input_active;
  wake_pkg::wake_cfg_s [4:0]     input_config;      // effective setup seen
  logic [2:0]                    fl_m [5];          // expected filter per input
  logic [1:0]                    pl_m [5];          // expected pull per input
  logic [1:0]                    en_m [5];          // expected enable per input
  logic                          role_m;            // expected role bit
  logic [2:0]                    bank_m;            // expected bank
  int                            fail_count, checked;

  wake_source_control i_wake_source_control (.mclk(mclk), .rst(rst), .restart_rst(restart_rst),
    .dev_mode(dev_mode), .system_error_flag(system_error_flag), .sleep_entry(sleep_entry),
    .stop_entry(stop_entry), .failsafe_entry(failsafe_entry), .failsafe_active(failsafe_active),
    .restart_can_low(restart_can_low), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .transceiver_mode(transceiver_mode),
    .shared_pin_role_select(shared_pin_role_select), .strobe_input_active(strobe_input_active),
    .input_config(input_config));
  wake_host_model i_wake_host_model (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ****************************************************************
  // compare and report
  // ****************************************************************
  task automatic chk_data(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_mode(input string n, input wake_pkg::can_mode_t e, input wake_pkg::can_mode_t g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_field(input string n, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // expectations
  // ****************************************************************
  // read image of the wake control register from the model
  function automatic logic [15:0] exp_wk();
    logic [2:0] b;
    b = bank_m;
    return {(b == 3'h1) ? role_m : 1'b0, 1'b0, fl_m[b], (b == 3'h4) ? 2'h0 : pl_m[b], 2'h0, en_m[b], 2'h0, b};
  endfunction

  // mode after an event: k 0 sleep, 1 sleep with error, 2 stop
  function automatic wake_pkg::can_mode_t exp_mode(input logic [2:0] m, input int k);
    logic [1:0] lo;
    lo = m[1:0];
    if (k < 2 && (lo == 2'h2 || (lo == 2'h3 && k == 0)))
      lo = 2'h1;
    return {m[2], lo};
  endfunction

  // wake control write, model update, read back
  task automatic wk(input logic r, input logic [2:0] f, input logic [1:0] p, input logic [1:0] e,
                    input logic [2:0] b);
    i_wake_host_model.wr(7'h05, {r, 1'b0, f, p, 2'h0, e, 2'h0, b});
    if (b <= 3'h4)
    begin
      bank_m = b;
      if (b == 3'h1)
        role_m = r;
      if (f <= 3'h4)
        fl_m[b] = f;
      if (b != 3'h4)
        pl_m[b] = p;
      en_m[b] = e;
    end
    i_wake_host_model.rd(7'h05, rd_val);
    chk_data("wake ctrl", exp_wk(), rd_val);
  endtask

  // effective per-input setup against the model
  task automatic chk_cfg();
    logic [2:0] f;
    for (int i = 0; i < 5; i++)
    begin
      f = (failsafe_active || (fl_m[i] == 3'h4 && en_m[3] != 2'h2)) ? 3'h0 : fl_m[i];
      chk_field("filter", f, input_config[i].filter);
      chk_field("pull", (i == 4) ? 3'h2 : {1'b0, pl_m[i]}, {1'b0, input_config[i].pull});
      chk_field("enable", {1'b0, (en_m[i] == 2'h1 && !(i == 1 && !role_m)) ? 2'h1 : 2'h0},
                {1'b0, input_config[i].enable});
    end
    chk_field("strobe", {2'h0, en_m[3] == 2'h2}, {2'h0, strobe_input_active});
    chk_field("role", {2'h0, role_m}, {2'h0, shared_pin_role_select});
  endtask

  // one-cycle event pulse: 0 sleep, 1 stop, 2 fail-safe, 3 restart
  task automatic pulse(input int k);
    @(negedge mclk);
    sleep_entry    = (k == 0);
    stop_entry     = (k == 1);
    failsafe_entry = (k == 2);
    restart_rst    = (k == 3);
    @(negedge mclk);
    {sleep_entry, stop_entry, failsafe_entry, restart_rst} = 4'h0;
    repeat (2) @(negedge mclk);
  endtask

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // hang guard, far beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    fail_count++;
    conclude();
  end

  initial
  begin
    void'($urandom(22283));
    {rst, dev_mode, restart_rst, system_error_flag} = 4'h8;
    {sleep_entry, stop_entry, failsafe_entry, failsafe_active, restart_can_low} = 6'h00;
    for (int i = 0; i < 5; i++)
      {fl_m[i], pl_m[i], en_m[i]} = 7'h01;
    {role_m, bank_m, fail_count, checked} = '0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    // reset values, unmapped place
    chk_mode("mode reset", 3'h0, transceiver_mode);
    chk_field("fixed pull", 3'h2, {1'b0, input_config[4].pull});
    i_wake_host_model.wr(7'h10, 16'(($urandom)));
    i_wake_host_model.rd(7'h05, rd_val);
    chk_data("wake reset", 16'h0020, rd_val);
    i_wake_host_model.rd(7'h04, rd_val);
    chk_data("bus reset", 16'h0000, rd_val);
    i_wake_host_model.rd(7'h10, rd_val);
    chk_data("unmapped", 16'h0000, rd_val);
    // corners: role outside bank 2, reserved bank, reserved filter, strobe use
    wk(1'b1, 3'h1, 2'h3, 2'h1, 3'h0);
    wk(1'b1, 3'h0, 2'h2, 2'h1, 3'h1);
    wk(1'b0, 3'h2, 2'h1, 2'h1, 3'h6);
    wk(1'b0, 3'h5, 2'h1, 2'h2, 3'h3);
    wk(1'b0, 3'h4, 2'h3, 2'h1, 3'h4);
    chk_cfg();
    // random per-bank traffic, then fourth input set back to strobe
    for (int n = 0; n < 24; n++)
    begin
      wk(1'(($urandom)), 3'($urandom_range(0, 7)), 2'(($urandom)), 2'(($urandom)), 3'($urandom_range(0, 7)));
      if (n % 6 == 5)
        chk_cfg();
    end
    wk(1'b0, 3'h0, 2'h0, 2'h2, 3'h3);
    chk_cfg();
    // every mode against sleep, sleep with error, stop
    for (int m = 0; m < 8; m++)
      for (int k = 0; k < 3; k++)
      begin
        i_wake_host_model.wr(7'h04, {13'h0, m[2:0]});
        system_error_flag = (k == 1);
        pulse((k == 2) ? 1 : 0);
        chk_mode("mode event", exp_mode(m[2:0], k), transceiver_mode);
      end
    i_wake_host_model.rd(7'h04, rd_val);
    chk_data("bus read", {13'h0, exp_mode(3'h7, 2)}, rd_val);
    // fail-safe entry with second input as fail output, fourth as strobe
    wk(1'b0, 3'h1, 2'h1, 2'h0, 3'h1);
    wk(1'b0, 3'h3, 2'h3, 2'h3, 3'h2);
    i_wake_host_model.wr(7'h04, 16'h0007);
    failsafe_active = 1'b1;
    pulse(2);
    for (int i = 0; i < 5; i++)
      if (!(i == 1 && !role_m) && !(i == 3 && en_m[3] == 2'h2))
        en_m[i] = 2'h1;
    chk_mode("fail-safe mode", 3'h1, transceiver_mode);
    chk_cfg();
    failsafe_active = 1'b0;
    repeat (2) @(negedge mclk);
    chk_cfg();
    // restart reset loads cause bits and bank one
    restart_can_low = 2'(($urandom));
    i_wake_host_model.wr(7'h04, 16'h0006);
    pulse(3);
    bank_m = 3'h0;
    chk_mode("restart mode", {1'b0, restart_can_low}, transceiver_mode);
    i_wake_host_model.rd(7'h05, rd_val);
    chk_data("restart wake", exp_wk(), rd_val);
    // second reset in development mode
    @(negedge mclk);
    {rst, dev_mode} = 2'h3;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    dev_mode = 1'b0;
    chk_mode("dev reset", 3'h1, transceiver_mode);
    conclude();
  end
endmodule // test_wake_source_control

`default_nettype wire
